/* File: evc_consts.svh */
/*
  Offsets, field positions, reset values and timing figures of the event counter.
  Assumes a 40 MHz clock and a 32-bit register port with byte addresses.
*/
`ifndef EVC_CONSTS_SVH
`define EVC_CONSTS_SVH

`define EVC_CLK_KHZ 40000
`define EVC_SHORT_MIN_MS 100
`define EVC_LONG_MIN_MS 350
`define EVC_MAX_MS 30000

`define EVC_OFS_CTRL 8'h00
`define EVC_OFS_BOUND 8'h04
`define EVC_OFS_PRESET 8'h08
`define EVC_OFS_COUNT 8'h0c
`define EVC_OFS_FLAGS 8'h10
`define EVC_OFS_IRQ_STATUS 8'h14
`define EVC_OFS_IRQ_CLEAR 8'h18
`define EVC_OFS_IRQ_ENABLE 8'h1c

`define EVC_CTRL_OVF_AUTO 0
`define EVC_CTRL_UNF_AUTO 1
`define EVC_CTRL_CLR_LONG 2
`define EVC_CTRL_PRE_LONG 3

`define EVC_EV_OVERFLOW 0
`define EVC_EV_UNDERFLOW 1
`define EVC_EV_CLEAR 2
`define EVC_EV_PRESET 3
`define EVC_EV_REJECT 4
`define EVC_EV_W 5

`define EVC_CTRL_RST 4'h0
`define EVC_BOUND_RST 16'hffff
`define EVC_PRESET_RST 16'h0001

`endif

/* File: evc_pkg.sv */
/*
  Types of the event counter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package evc_pkg;
  typedef enum logic [2:0] {
    EVC_UP = 3'h1,
    EVC_DOWN = 3'h2,
    EVC_UP_DOWN = 3'h4
  } evc_variant_t;
endpackage : evc_pkg

/* File: evc_counter.sv */
/*
  Event counter with up/down edge inputs, width-qualified clear and preset pulses,
  overflow and underflow flags, register port and interrupt.
  Assumes asynchronous pins, one 40 MHz clock, a master that never overlaps strobes.
*/
// Local design decisions: the address map and the strobed register port.
// How it works
// - Each rising edge on the up input adds one to the count.
// - Each rising edge on the down input takes one from the count.
// - Up and down edges together leave the count unchanged.
// - A valid clear pulse forces the count to zero in every mode.
// - Clear pulse valid only if high between selected minimum and thirty seconds.
// - A valid preset pulse loads the preset value in every mode unless a valid clear comes in the same cycle.
// - Preset pulse valid only if high between selected minimum and thirty seconds.
// - Overflow flags reaching the bound, underflow flags reaching zero.
// - Built as up only, down only, or up and down counter.
// - Automatic overflow: flag for one cycle, then count returns to zero.
// - Manual overflow: flag holds, up edges ignored until count changes.
// - Automatic underflow: flag for one cycle, then preset value loaded.
// - Manual underflow: flag holds, down edges ignored until count changes.
`include "evc_consts.svh"

module evc_counter #(
  parameter evc_pkg::evc_variant_t VARIANT = evc_pkg::EVC_UP_DOWN,
  parameter int unsigned SHORT_MIN_CYC = `EVC_SHORT_MIN_MS * `EVC_CLK_KHZ,
  parameter int unsigned LONG_MIN_CYC = `EVC_LONG_MIN_MS * `EVC_CLK_KHZ,
  parameter int unsigned MAX_CYC = `EVC_MAX_MS * `EVC_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic up_in,
  input wire logic down_in,
  input wire logic clear_request,
  input wire logic preset_request,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic [15:0] count_value,
  output logic overflow,
  output logic underflow,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [3:0] in_meta_reg;
  logic [3:0] in_sync_reg;
  logic [3:0] in_prev_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_reg <= 4'h0;
      in_sync_reg <= 4'h0;
      in_prev_reg <= 4'h0;
    end else begin
      in_meta_reg <= {preset_request, clear_request, down_in, up_in};
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and pulse width qualification

  logic [3:0] ctrl_reg;
  logic [15:0] bound_reg;
  logic [15:0] preset_reg;
  logic [31:0] clr_width_reg;
  logic [31:0] pre_width_reg;
  logic up_edge;
  logic dn_edge;
  logic clr_fall;
  logic pre_fall;
  logic clr_valid;
  logic pre_valid;

  function automatic logic [31:0] width_step(input logic level, input logic [31:0] w);
    if (!level) begin
      return 32'h0;
    end
    return (w > MAX_CYC) ? w : w + 32'h1;
  endfunction : width_step

  function automatic logic width_ok(input logic [31:0] w, input logic long_sel);
    logic [31:0] min_cyc;
    min_cyc = long_sel ? LONG_MIN_CYC : SHORT_MIN_CYC;
    return (w >= min_cyc) && (w <= MAX_CYC);
  endfunction : width_ok

  assign up_edge = in_sync_reg[0] & ~in_prev_reg[0] & (VARIANT != evc_pkg::EVC_DOWN);
  assign dn_edge = in_sync_reg[1] & ~in_prev_reg[1] & (VARIANT != evc_pkg::EVC_UP);
  assign clr_fall = in_prev_reg[2] & ~in_sync_reg[2];
  assign pre_fall = in_prev_reg[3] & ~in_sync_reg[3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_width_reg <= 32'h0;
      pre_width_reg <= 32'h0;
    end else begin
      clr_width_reg <= width_step(in_sync_reg[2], clr_width_reg);
      pre_width_reg <= width_step(in_sync_reg[3], pre_width_reg);
    end
  end

  assign clr_valid = clr_fall & width_ok(clr_width_reg, ctrl_reg[`EVC_CTRL_CLR_LONG]);
  assign pre_valid = pre_fall & width_ok(pre_width_reg, ctrl_reg[`EVC_CTRL_PRE_LONG]);

  ////////////////////////////////////////////////////////////////////////////
  // Count and flags

  logic [15:0] count_reg;
  logic ovf_reg;
  logic unf_reg;
  logic ovf_wrap;
  logic unf_wrap;
  logic quiet;

  assign ovf_wrap = ovf_reg & ctrl_reg[`EVC_CTRL_OVF_AUTO] & (count_reg == bound_reg);
  assign unf_wrap = unf_reg & ctrl_reg[`EVC_CTRL_UNF_AUTO] & (count_reg == 16'h0);
  assign quiet = ~clr_valid & ~pre_valid & ~ovf_wrap & ~unf_wrap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (clr_valid) begin
      count_reg <= 16'h0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (pre_valid) begin
      count_reg <= preset_reg;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (ovf_wrap) begin
      count_reg <= 16'h0;
      ovf_reg <= 1'b0;
    end else if (unf_wrap) begin
      count_reg <= preset_reg;
      unf_reg <= 1'b0;
    end else if (up_edge && dn_edge) begin
      count_reg <= count_reg;
    end else if (up_edge) begin
      if (count_reg >= bound_reg || (ovf_reg && !ctrl_reg[`EVC_CTRL_OVF_AUTO])) begin
        ovf_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 16'h1;
        ovf_reg <= (count_reg + 16'h1) == bound_reg;
        unf_reg <= 1'b0;
      end
    end else if (dn_edge) begin
      if (count_reg == 16'h0) begin
        unf_reg <= 1'b1;
      end else begin
        count_reg <= count_reg - 16'h1;
        unf_reg <= count_reg == 16'h1;
        ovf_reg <= 1'b0;
      end
    end
  end

  assign count_value = count_reg;
  assign overflow = ovf_reg;
  assign underflow = unf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt

  logic ovf_prev_reg;
  logic unf_prev_reg;
  logic [`EVC_EV_W-1:0] events;
  logic [`EVC_EV_W-1:0] irq_status_reg;
  logic [`EVC_EV_W-1:0] irq_enable_reg;
  logic [`EVC_EV_W-1:0] irq_clear;
  logic irq_reg;
  logic [31:0] rdata_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_prev_reg <= 1'b0;
      unf_prev_reg <= 1'b0;
    end else begin
      ovf_prev_reg <= ovf_reg;
      unf_prev_reg <= unf_reg;
    end
  end

  always_comb begin
    events = '0;
    events[`EVC_EV_OVERFLOW] = ovf_reg & ~ovf_prev_reg;
    events[`EVC_EV_UNDERFLOW] = unf_reg & ~unf_prev_reg;
    events[`EVC_EV_CLEAR] = clr_valid;
    events[`EVC_EV_PRESET] = pre_valid;
    events[`EVC_EV_REJECT] = (clr_fall & ~clr_valid) | (pre_fall & ~pre_valid);
  end

  assign irq_clear = (wr_en && addr == `EVC_OFS_IRQ_CLEAR) ? wdata[`EVC_EV_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `EVC_CTRL_RST;
      bound_reg <= `EVC_BOUND_RST;
      preset_reg <= `EVC_PRESET_RST;
      irq_enable_reg <= '0;
    end else if (wr_en) begin
      case (addr)
        `EVC_OFS_CTRL: ctrl_reg <= wdata[3:0];
        `EVC_OFS_BOUND: bound_reg <= wdata[15:0];
        `EVC_OFS_PRESET: preset_reg <= wdata[15:0];
        `EVC_OFS_IRQ_ENABLE: irq_enable_reg <= wdata[`EVC_EV_W-1:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | events;
      irq_reg <= |(((irq_status_reg & ~irq_clear) | events) & irq_enable_reg);
    end
  end
  assign irq = irq_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else if (rd_en) begin
      case (addr)
        `EVC_OFS_CTRL: rdata_reg <= {28'h0, ctrl_reg};
        `EVC_OFS_BOUND: rdata_reg <= {16'h0, bound_reg};
        `EVC_OFS_PRESET: rdata_reg <= {16'h0, preset_reg};
        `EVC_OFS_COUNT: rdata_reg <= {16'h0, count_reg};
        `EVC_OFS_FLAGS: rdata_reg <= {30'h0, unf_reg, ovf_reg};
        `EVC_OFS_IRQ_STATUS: rdata_reg <= {27'h0, irq_status_reg};
        `EVC_OFS_IRQ_ENABLE: rdata_reg <= {27'h0, irq_enable_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_wrapped_zero;
    count_reg == 16'h0 && !ovf_reg;
  endsequence
  property p_up_count;
    quiet && up_edge && !dn_edge && count_reg < bound_reg |=> count_reg == $past(count_reg) + 16'h1;
  endproperty
  a_up_count: assert property (p_up_count) else $error("up edge did not add one");
  property p_dn_count;
    quiet && dn_edge && !up_edge && count_reg != 16'h0 |=> count_reg == $past(count_reg) - 16'h1;
  endproperty
  a_dn_count: assert property (p_dn_count) else $error("down edge did not take one");
  property p_both_hold;
    quiet && up_edge && dn_edge |=> $stable(count_reg);
  endproperty
  a_both_hold: assert property (p_both_hold) else $error("simultaneous edges changed count");
  property p_clear;
    clr_valid |=> count_reg == 16'h0 && !ovf_reg && !unf_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("valid clear did not zero count");
  property p_short_clear;
    clr_fall && clr_width_reg < SHORT_MIN_CYC |-> !clr_valid;
  endproperty
  a_short_clear: assert property (p_short_clear) else $error("short clear pulse accepted");
  property p_preset;
    pre_valid && !clr_valid |=> count_reg == $past(preset_reg) && !ovf_reg && !unf_reg;
  endproperty
  a_preset: assert property (p_preset) else $error("valid preset did not load");
  property p_long_preset;
    pre_fall && pre_width_reg > MAX_CYC |-> !pre_valid;
  endproperty
  a_long_preset: assert property (p_long_preset) else $error("overlong preset pulse accepted");
  property p_ovf_flag;
    quiet && up_edge && !dn_edge && count_reg + 16'h1 == bound_reg |=> overflow;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged at bound");
  property p_ovf_auto;
    ovf_wrap && !clr_valid && !pre_valid |=> s_wrapped_zero;
  endproperty
  a_ovf_auto: assert property (p_ovf_auto) else $error("automatic overflow did not wrap");
  property p_ovf_manual;
    ovf_reg && !ctrl_reg[`EVC_CTRL_OVF_AUTO] && quiet && up_edge && !dn_edge |=> ovf_reg && $stable(count_reg);
  endproperty
  a_ovf_manual: assert property (p_ovf_manual) else $error("manual overflow not held");
  property p_unf_auto;
    unf_wrap && !clr_valid && !pre_valid && !ovf_wrap |=> count_reg == $past(preset_reg) && !unf_reg;
  endproperty
  a_unf_auto: assert property (p_unf_auto) else $error("automatic underflow did not reload");
  property p_prio;
    clr_valid && pre_valid |=> count_reg == 16'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("preset beat clear");

endmodule : evc_counter

/* File: evc_pin_source.sv */
/*
  Far side of the event counter: controller logic driving the four pin inputs.
  Assumes the bench calls pulse() and that pins change only right after a rising edge.
*/
module evc_pin_source (
  input wire logic clk,
  output logic up_in,
  output logic down_in,
  output logic clear_request,
  output logic preset_request
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {preset_request, clear_request, down_in, up_in} = 4'h0;
  end

  ////////////////////////////////////////////////////////////
  // low high low
  // Mask bits: 0 up, 1 down, 2 clear, 3 preset; n high cycles, then settle
  task automatic pulse(input logic [3:0] sel, input int n);
    @(posedge clk);
    {preset_request, clear_request, down_in, up_in} <= sel;
    repeat (n) @(posedge clk);
    {preset_request, clear_request, down_in, up_in} <= 4'h0;
    repeat (8) @(posedge clk);
  endtask : pulse
endmodule : evc_pin_source

/* File: event_up_down_counter_test.sv */
/*
  Self-checking bench of the event counter with shortened pulse limits.
  Assumes evc_pin_source drives the pins and the bench owns the register port.
*/
`include "evc_consts.svh"

module event_up_down_counter_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic up_in, down_in, clear_request, preset_request;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [15:0] count_value;
  logic overflow, underflow, irq;
  int mismatches = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  evc_pin_source i_evc_pin_source (.clk(clk), .up_in(up_in), .down_in(down_in),
    .clear_request(clear_request), .preset_request(preset_request));

  evc_counter #(.VARIANT(evc_pkg::EVC_UP_DOWN), .SHORT_MIN_CYC(10), .LONG_MIN_CYC(35), .MAX_CYC(200))
  i_evc_counter (.clk(clk), .rst_b(rst_b), .up_in(up_in), .down_in(down_in), .clear_request(clear_request),
    .preset_request(preset_request), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .count_value(count_value), .overflow(overflow), .underflow(underflow), .irq(irq));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata);
  endtask : chk_reg

  task automatic chk_state(input logic [15:0] cnt, input logic ovf, input logic unf);
    chk("count", {16'h0, cnt}, {16'h0, count_value});
    chk("flags", {30'h0, unf, ovf}, {30'h0, underflow, overflow});
  endtask : chk_state

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_reg(`EVC_OFS_CTRL, 32'h0);
    chk_reg(`EVC_OFS_BOUND, 32'h0000ffff);
    chk_reg(`EVC_OFS_PRESET, 32'h00000001);
    wr(`EVC_OFS_COUNT, 32'h7);
    wr(8'h24, 32'h5);
    chk_reg(`EVC_OFS_COUNT, 32'h0);
    chk_reg(8'h24, 32'h0);
  endtask : t_reset

  task automatic t_count();
    repeat (3) i_evc_pin_source.pulse(4'h1, 2);
    chk_state(16'h3, 1'b0, 1'b0);
    i_evc_pin_source.pulse(4'h2, 2);
    chk_state(16'h2, 1'b0, 1'b0);
    i_evc_pin_source.pulse(4'h3, 2);
    chk_state(16'h2, 1'b0, 1'b0);
  endtask : t_count

  task automatic t_overflow();
    wr(`EVC_OFS_BOUND, 32'h5);
    repeat (3) i_evc_pin_source.pulse(4'h1, 2);
    chk_state(16'h5, 1'b1, 1'b0);
    i_evc_pin_source.pulse(4'h1, 2);
    chk_state(16'h5, 1'b1, 1'b0);
    i_evc_pin_source.pulse(4'h2, 2);
    chk_state(16'h4, 1'b0, 1'b0);
    wr(`EVC_OFS_CTRL, 32'h1);
    wr(`EVC_OFS_IRQ_CLEAR, 32'h1f);
    i_evc_pin_source.pulse(4'h1, 2);
    chk_state(16'h0, 1'b0, 1'b0);
    chk_reg(`EVC_OFS_IRQ_STATUS, 32'h1);
  endtask : t_overflow

  task automatic t_underflow();
    wr(`EVC_OFS_CTRL, 32'h0);
    i_evc_pin_source.pulse(4'h1, 2);
    i_evc_pin_source.pulse(4'h2, 2);
    chk_state(16'h0, 1'b0, 1'b1);
    i_evc_pin_source.pulse(4'h2, 2);
    chk_state(16'h0, 1'b0, 1'b1);
    i_evc_pin_source.pulse(4'h1, 2);
    chk_state(16'h1, 1'b0, 1'b0);
    wr(`EVC_OFS_PRESET, 32'h3);
    wr(`EVC_OFS_CTRL, 32'h2);
    wr(`EVC_OFS_IRQ_CLEAR, 32'h1f);
    wr(`EVC_OFS_IRQ_ENABLE, 32'h1);
    i_evc_pin_source.pulse(4'h2, 2);
    chk_state(16'h3, 1'b0, 1'b0);
    chk_reg(`EVC_OFS_IRQ_STATUS, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`EVC_OFS_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`EVC_OFS_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    chk_reg(`EVC_OFS_IRQ_STATUS, 32'h0);
    chk_reg(`EVC_OFS_IRQ_ENABLE, 32'h2);
  endtask : t_underflow

  // Widths straddle 10/35/200 cycles; long minimum selected from step 5
  task automatic t_pulses();
    logic [3:0] sel_tab [11] = '{4'h4, 4'h4, 4'h1, 4'h8, 4'h8, 4'h4, 4'h4, 4'h8, 4'h8, 4'hc, 4'hc};
    int n_tab [11] = '{5, 10, 2, 9, 10, 20, 35, 34, 200, 201, 40};
    logic [15:0] exp_tab [11] = '{16'h4, 16'h0, 16'h1, 16'h1, 16'h3, 16'h3, 16'h0, 16'h0, 16'h3, 16'h3, 16'h0};
    wr(`EVC_OFS_CTRL, 32'h0);
    i_evc_pin_source.pulse(4'h1, 2);
    for (int i = 0; i < 11; i++) begin
      if (i == 5) begin
        wr(`EVC_OFS_CTRL, 32'hc);
      end
      i_evc_pin_source.pulse(sel_tab[i], n_tab[i]);
      chk_state(exp_tab[i], 1'b0, 1'b0);
    end
    chk_reg(`EVC_OFS_IRQ_STATUS, 32'h1c);
  endtask : t_pulses

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_count();
    t_overflow();
    t_underflow();
    t_pulses();
    report_and_stop();
  end
endmodule : event_up_down_counter_test
